// ### host_serial_model.sv
// Host-side model: the first nbits of a command byte plus one data byte per call, LSB first.
// Expects the port's edge select strap and its output pin pair.
`timescale 1ns/1ps

module host_serial_model
(
    output logic     sclk,
    output logic     cs_n,
    output logic     serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic edge_sel
);
    import host_serial_pkg::*;
    localparam realtime HALF = 7.5;
    logic out_last = 1'b0;
    logic oe_seen  = 1'b0;
    // A floating pin reads as the inverse of its last value, so stale data cannot pass.
    wire  out_line = serial_data_out_oe ? serial_data_out : ~out_last;
    always @* if (serial_data_out_oe) out_last = serial_data_out;
    always @(posedge serial_data_out_oe) oe_seen = 1'b1;
    // Select rises once before any frame, since only that edge clears the port's serial state.
    initial
    begin
        sclk           = 1'b0;
        serial_data_in = 1'b0;
        cs_n           = 1'b0;
        #20;
        cs_n           = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nbits, output logic [7:0] rd);
        logic [15:0] tx;
        tx      = {wd, cmd};
        rd      = 8'h00;
        oe_seen = 1'b0;
        cs_n    = 1'b0;
        for (int n = 1; n <= nbits; n++)
        begin
            serial_data_in = tx[n - 1];
            #HALF;
            if (edge_sel && n > 8) rd[n - 9] = out_line;
            sclk = 1'b1;
            #HALF;
            if (!edge_sel && n > 8) rd[n - 9] = out_line;
            sclk = 1'b0;
        end
        #50 cs_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #15;
    endtask : xfer
endmodule : host_serial_model

// ### host_serial_pkg.sv
// Shared constants and carriers for the host-mode serial control port.
// Assumes a single compile unit; every design file imports this package whole.
package host_serial_pkg;

    // Serial frame layout, counted in rising serial clock edges after select falls.
    localparam logic [4:0] CNT_CMD_LAST  = 5'h07;
    localparam logic [4:0] CNT_CMD_DONE  = 5'h08;
    localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
    localparam logic [4:0] CNT_POS_FIRST = 5'h09;
    localparam logic [4:0] CNT_POS_LAST  = 5'h10;
    localparam logic [4:0] CNT_STOP      = 5'h11;

    // Command byte: bit 0 direction, bits 1 to 6 address, bit 7 ignored.
    localparam int         CMD_DIR_BIT   = 0;
    localparam int         CMD_ADDR_LO   = 1;
    localparam int         CMD_ADDR_HI   = 6;
    localparam logic       CMD_READ      = 1'b1;
    localparam logic [5:0] DEV_ADDR      = 6'h10;

    // Status byte field positions.
    localparam int         RD_SLOSS_BIT  = 0;
    localparam int         RD_DFAULT_BIT = 1;
    localparam int         RD_LEN_LO     = 2;
    localparam int         RD_LEN_HI     = 4;

    // Mode codes, written as bit 5, bit 6, bit 7 from left to right.
    localparam logic [2:0] CODE_IDLE     = 3'h0;
    localparam logic [2:0] CODE_ONES     = 3'h1;
    localparam logic [2:0] CODE_LOCAL_LOOPBACK    = 3'h2;
    localparam logic [2:0] CODE_ONES_LL  = 3'h3;
    localparam logic [2:0] CODE_REMOTE_LOOPBACK    = 3'h4;
    localparam logic [2:0] CODE_DFAULT   = 3'h5;
    localparam logic [2:0] CODE_SLOSS    = 3'h6;
    localparam logic [2:0] CODE_BOTH     = 3'h7;

    localparam logic [7:0] BYTE_RESET    = 8'h00;

    // Control byte as it arrives, least significant bit first on the wire.
    typedef struct packed {
        logic       transmit_all_ones;
        logic       local_loopback;
        logic       remote_loopback;
        logic [2:0] line_length;
        logic       driver_fault_clear;
        logic       signal_loss_clear;
    } ctrl_s;

endpackage : host_serial_pkg

// ### line_serial_port.sv
// Host-mode serial control port: one write-only control byte, one read-only status byte.
// Assumes the alarm detectors and loopback datapaths sit outside and meet it at plain pins.
//
// Overview of operation
// [R01] A transfer starts only on a high-to-low select; select high holds the port idle.
// [R02] Command and write data bits are sampled on rising serial clock edges.
// [R03] Host raises select no sooner than 50 ns after the last written bit's edge.
// [R04] During a read, raising select stops output data at once.
// [R05] Last read bit held to falling edge 16 (select high) or rising edge 17.
// [R06] Edge select high: read data valid on rising edges; low: on falling edges.
// [R07] Edge select also picks receive data edge: falling when high, rising when low.
// [R08] Serial output floats after select rises or the last bit's hold ends, and when idle.
// [R09] Command byte is sent LSB first; bit 0 is 0 for write, 1 for read.
// [R10] Command bits 1 to 6 must equal address 16; bit 7 is ignored.
// [R11] Write data follows the command byte in the next eight clocks, no gap.
// [R12] Write byte: two clears, three line-length bits, remote, local loopback, all-ones.
// [R13] Writing a clear bit as 1 releases the interrupt; reading never does.
// [R14] A set clear bit also resets the mode code and masks that source.
// [R15] Writing a clear bit as 0 re-enables interrupts from that source.
// [R16] Read byte: signal loss bit 0, driver fault bit 1, line length bits 2 to 4.
// [R17] Bits 5 to 7 show idle, all-ones, local loopback, both, or remote loopback.
// [R18] Bits 5 to 7 show 101, 110 or 111 for driver, signal-loss or both changes.
// [R19] Interrupt pin pulls low on any alarm change until the matching clear is written.
// [R20] Port timing comes only from serial clock and select, not the line clocks.
// [R21] Writing both loopbacks resets all registers and forces the signal-loss flag high.
// [R22] Serial output stays floating through every write transfer.
// [R23] On address mismatch the data byte is ignored and the output stays floating.
`timescale 1ns/1ps

module line_serial_port
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  serial_data_in,
    input  wire logic                  clock_edge_select,
    input  wire logic                  signal_loss_in,
    input  wire logic                  driver_fault_in,
    input  wire logic                  rclk,
    input  wire logic                  rx_pos_in,
    input  wire logic                  rx_neg_in,
    output logic                       serial_data_out,
    output logic                       serial_data_out_oe,
    output logic                       int_n_out,
    output logic                       int_n_oe,
    output host_serial_pkg::ctrl_s     line_ctrl,
    output logic                       device_reset_pulse,
    output logic                       receive_positive_data,
    output logic                       receive_negative_data
);
    import host_serial_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock domain, rising edge. Select high clears it without a clock, since
    // the host may stop the serial clock as soon as it deselects.

    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] cmd;
        logic [7:0] data;
        logic       edge_s1;
        logic       edge_s2;
        logic [7:0] stat_s1;
        logic [7:0] stat_s2;
        logic [7:0] snap;
        logic       pos_bit;
        logic       pos_oe;
        logic       wr_done;
    } link_s;

    link_s      link_r;
    link_s      link_nxt;
    logic [7:0] wr_hold_r;
    logic       cmd_ok;
    logic       neg_bit_r;
    logic       neg_oe_r;
    logic [7:0] status_r;

    // Bit 7 of the command is a don't-care.
    assign cmd_ok = (link_r.cmd[CMD_ADDR_HI:CMD_ADDR_LO] == DEV_ADDR); // [R10]

    always_comb
    begin
        logic [4:0] cnt_inc;
        cnt_inc  = link_r.cnt + 5'h01;
        link_nxt = link_r;
        link_nxt.edge_s1 = clock_edge_select;
        link_nxt.edge_s2 = link_r.edge_s1;
        link_nxt.stat_s1 = status_r;
        link_nxt.stat_s2 = link_r.stat_s1;
        if (link_r.cnt != CNT_STOP)
        begin
            link_nxt.cnt = cnt_inc;
        end
        if (link_r.cnt <= CNT_CMD_LAST)
        begin
            link_nxt.cmd = {serial_data_in, link_r.cmd[7:1]}; // [R02] [R09]
        end
        if (link_r.cnt == CNT_CMD_LAST)
        begin
            // Status is frozen once per read, so the byte on the wire is coherent.
            link_nxt.snap = link_r.stat_s2;
        end
        if ((link_r.cnt >= CNT_CMD_DONE) && (link_r.cnt <= CNT_DATA_LAST))
        begin
            link_nxt.data = {serial_data_in, link_r.data[7:1]}; // [R02] [R11]
        end
        if ((link_r.cnt == CNT_DATA_LAST) && cmd_ok && (link_r.cmd[CMD_DIR_BIT] != CMD_READ))
        begin
            link_nxt.wr_done = 1'b1; // [R23]
        end
        link_nxt.pos_oe  = 1'b0;
        link_nxt.pos_bit = 1'b0;
        // Falling-edge-valid mode: launch on rising edges 9 to 16, drop on 17.
        if ((link_r.cnt >= CNT_CMD_DONE) && cmd_ok && (link_r.cmd[CMD_DIR_BIT] == CMD_READ)
            && (cnt_inc >= CNT_POS_FIRST) && (cnt_inc <= CNT_POS_LAST))
        begin
            link_nxt.pos_oe  = 1'b1; // [R05] [R06]
            link_nxt.pos_bit = link_r.snap[3'(cnt_inc - CNT_POS_FIRST)];
        end
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            link_r <= '0; // [R01] [R04] [R20]
        end
        else
        begin
            link_r <= link_nxt;
        end
    end

    // The written byte is kept outside the select-cleared state: the core domain
    // reads it a few cycles after select may already have risen again.
    always_ff @(posedge sclk)
    begin
        if ((link_r.cnt == CNT_DATA_LAST) && !cs_n)
        begin
            wr_hold_r <= link_nxt.data; // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock domain, falling edge: rising-edge-valid mode launches bits here
    // on falling edges 8 to 15, so the last bit is held to falling edge 16.

    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            neg_oe_r  <= 1'b0; // [R04] [R08]
            neg_bit_r <= 1'b0;
        end
        else if ((link_r.cnt >= CNT_CMD_DONE) && (link_r.cnt <= CNT_DATA_LAST) && cmd_ok
                 && (link_r.cmd[CMD_DIR_BIT] == CMD_READ))
        begin
            neg_oe_r  <= 1'b1; // [R05] [R06]
            neg_bit_r <= link_r.snap[3'(link_r.cnt - CNT_CMD_DONE)];
        end
        else
        begin
            neg_oe_r  <= 1'b0; // [R08] [R22] [R23]
            neg_bit_r <= 1'b0;
        end
    end

    // The output is picked between two flops, one per launch edge, by the edge select.
    always_comb
    begin
        serial_data_out    = link_r.edge_s2 ? neg_bit_r : link_r.pos_bit; // [R06]
        serial_data_out_oe = link_r.edge_s2 ? neg_oe_r : link_r.pos_oe;   // [R08]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain on ref_clk: control byte, alarm change tracking, interrupt.

    typedef struct packed {
        ctrl_s      ctrl;
        logic       wr_s1;
        logic       wr_s2;
        logic       wr_s3;
        logic       sloss_s1;
        logic       sloss_s2;
        logic       sloss_prev;
        logic       dfault_s1;
        logic       dfault_s2;
        logic       dfault_prev;
        logic       sloss_chg;
        logic       dfault_chg;
        logic       sloss_force;
        logic       int_act;
        logic       dev_reset;
        logic [7:0] status;
    } core_s;

    core_s core_r;
    core_s core_nxt;

    always_comb
    begin
        ctrl_s      wr;
        logic       wr_take;
        logic       sloss_evt;
        logic       dfault_evt;
        logic       sloss_now;
        logic [2:0] code;
        wr         = ctrl_s'(wr_hold_r);
        code       = CODE_IDLE;
        core_nxt   = core_r;
        core_nxt.wr_s1     = link_r.wr_done;
        core_nxt.wr_s2     = core_r.wr_s1;
        core_nxt.wr_s3     = core_r.wr_s2;
        core_nxt.sloss_s1  = signal_loss_in;
        core_nxt.sloss_s2  = core_r.sloss_s1;
        core_nxt.dfault_s1 = driver_fault_in;
        core_nxt.dfault_s2 = core_r.dfault_s1;
        core_nxt.sloss_prev  = core_r.sloss_s2;
        core_nxt.dfault_prev = core_r.dfault_s2;
        core_nxt.dev_reset   = 1'b0;
        wr_take    = core_r.wr_s2 && !core_r.wr_s3;
        // A source masked by a standing clear bit raises no change event.
        sloss_evt  = (core_r.sloss_s2 != core_r.sloss_prev) && !core_r.ctrl.signal_loss_clear;   // [R14] [R15]
        dfault_evt = (core_r.dfault_s2 != core_r.dfault_prev) && !core_r.ctrl.driver_fault_clear; // [R14] [R15]
        if (core_r.sloss_s2)
        begin
            core_nxt.sloss_force = 1'b0;
        end
        if (wr_take && wr.remote_loopback && wr.local_loopback)
        begin
            core_nxt.ctrl        = ctrl_s'(BYTE_RESET); // [R21]
            core_nxt.sloss_chg   = 1'b0;
            core_nxt.dfault_chg  = 1'b0;
            core_nxt.sloss_force = 1'b1;
            core_nxt.dev_reset   = 1'b1;
        end
        else
        begin
            if (wr_take)
            begin
                core_nxt.ctrl = wr; // [R12]
            end
            // A change arriving with the clearing write survives it.
            core_nxt.sloss_chg  = (core_r.sloss_chg && !(wr_take && wr.signal_loss_clear)) || sloss_evt;    // [R13]
            core_nxt.dfault_chg = (core_r.dfault_chg && !(wr_take && wr.driver_fault_clear)) || dfault_evt; // [R13]
        end
        core_nxt.int_act = core_nxt.sloss_chg || core_nxt.dfault_chg; // [R19]
        if (core_r.sloss_chg && core_r.dfault_chg)
        begin
            code = CODE_BOTH; // [R18]
        end
        else if (core_r.sloss_chg)
        begin
            code = CODE_SLOSS; // [R18]
        end
        else if (core_r.dfault_chg)
        begin
            code = CODE_DFAULT; // [R18]
        end
        else if (core_r.ctrl.remote_loopback)
        begin
            code = CODE_REMOTE_LOOPBACK; // [R17]
        end
        else if (core_r.ctrl.local_loopback && core_r.ctrl.transmit_all_ones)
        begin
            code = CODE_ONES_LL; // [R17]
        end
        else if (core_r.ctrl.local_loopback)
        begin
            code = CODE_LOCAL_LOOPBACK; // [R17]
        end
        else if (core_r.ctrl.transmit_all_ones)
        begin
            code = CODE_ONES; // [R17]
        end
        else
        begin
            code = CODE_IDLE; // [R17]
        end
        sloss_now = core_r.sloss_s2 || core_r.sloss_force; // [R21]
        core_nxt.status = {code[0], code[1], code[2], core_r.ctrl.line_length,
                           core_r.dfault_s2, sloss_now}; // [R16]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            core_r <= '0;
        end
        else
        begin
            core_r <= core_nxt;
        end
    end

    assign status_r           = core_r.status;
    assign line_ctrl          = core_r.ctrl;
    assign device_reset_pulse = core_r.dev_reset;
    assign int_n_out          = 1'b0;
    assign int_n_oe           = core_r.int_act; // [R19]

    ////////////////////////////////////////////////////////////////////////////////
    // Recovered clock domain: receive data retimed on the edge the select asks for.

    logic rx_edge_s1_r;
    logic rx_edge_s2_r;
    logic rx_pos_rise_r;
    logic rx_neg_rise_r;
    logic rx_pos_fall_r;
    logic rx_neg_fall_r;

    always_ff @(posedge rclk)
    begin
        rx_edge_s1_r  <= clock_edge_select;
        rx_edge_s2_r  <= rx_edge_s1_r;
        rx_pos_fall_r <= rx_pos_in;
        rx_neg_fall_r <= rx_neg_in;
    end

    // Launching on one edge makes the data stable at the opposite one.
    always_ff @(negedge rclk)
    begin
        rx_pos_rise_r <= rx_pos_in;
        rx_neg_rise_r <= rx_neg_in;
    end

    assign receive_positive_data = rx_edge_s2_r ? rx_pos_fall_r : rx_pos_rise_r; // [R07]
    assign receive_negative_data = rx_edge_s2_r ? rx_neg_fall_r : rx_neg_rise_r; // [R07]

endmodule : line_serial_port

// ### line_serial_port_checker.sv
// Concurrent checks on the serial control port pins and its alarm outputs.
// Bound into every line_serial_port instance; sees only that module's ports.
`timescale 1ns/1ps

module line_serial_port_checker
(
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   sclk,
    input wire logic                   cs_n,
    input wire logic                   serial_data_in,
    input wire logic                   clock_edge_select,
    input wire logic                   signal_loss_in,
    input wire logic                   driver_fault_in,
    input wire logic                   rclk,
    input wire logic                   rx_pos_in,
    input wire logic                   rx_neg_in,
    input wire logic                   serial_data_out,
    input wire logic                   serial_data_out_oe,
    input wire logic                   int_n_out,
    input wire logic                   int_n_oe,
    input host_serial_pkg::ctrl_s      line_ctrl,
    input wire logic                   device_reset_pulse,
    input wire logic                   receive_positive_data,
    input wire logic                   receive_negative_data
);
    import host_serial_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire both_clr = line_ctrl.signal_loss_clear && line_ctrl.driver_fault_clear;
    wire no_clr   = !line_ctrl.signal_loss_clear && !line_ctrl.driver_fault_clear;
    ////////////////////////////////////////////////////////////////////////////////
    property p_oe_cs; cs_n |-> !serial_data_out_oe; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
    property p_int_val; int_n_out == 1'b0; endproperty
    a_int_val: assert property (p_int_val) else $error("interrupt pin drives high");
    property p_rst_val; $rose(rst_n) |-> line_ctrl == 8'h00 && !int_n_oe && !device_reset_pulse; endproperty
    a_rst_val: assert property (p_rst_val) else $error("state not cleared by reset");
    property p_pulse_one; device_reset_pulse |=> !device_reset_pulse; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
    property p_pulse_clr; device_reset_pulse |-> ##[0:3] (line_ctrl == 8'h00 && !int_n_oe); endproperty
    a_pulse_clr: assert property (p_pulse_clr) else $error("device reset left state");
    property p_mask; both_clr && $past(both_clr) |-> !int_n_oe; endproperty
    a_mask: assert property (p_mask) else $error("interrupt while both sources masked");
    // The clearing write and the release land in one cycle, so the new control byte is judged.
    property p_int_hold; int_n_oe ##1 (no_clr && !device_reset_pulse) |-> int_n_oe; endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt released without clear");
    sequence s_loss_rise;
        $rose(signal_loss_in) ##1 (!line_ctrl.signal_loss_clear && !device_reset_pulse) [*4];
    endsequence
    property p_alarm_int; s_loss_rise |-> ##[0:2] int_n_oe; endproperty
    a_alarm_int: assert property (p_alarm_int) else $error("no interrupt on signal loss");
    c_reset: cover property (device_reset_pulse);
    c_int: cover property ($fell(int_n_oe));
    c_read: cover property ($rose(serial_data_out_oe));
endmodule : line_serial_port_checker

bind line_serial_port line_serial_port_checker line_serial_port_checker_inst
(
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in),
    .clock_edge_select(clock_edge_select), .signal_loss_in(signal_loss_in), .driver_fault_in(driver_fault_in),
    .rclk(rclk), .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .line_ctrl(line_ctrl), .device_reset_pulse(device_reset_pulse),
    .receive_positive_data(receive_positive_data), .receive_negative_data(receive_negative_data)
);

// ### line_serial_port_test.sv
// Self-checking bench for the host serial control port.
// Frames come from the host model; alarm and receive pins are driven here.
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module line_serial_port_test;
    import host_serial_pkg::*;
    logic       ref_clk  = 1'b0;
    logic       rclk     = 1'b0;
    logic       rst_n    = 1'b0;
    logic       edge_sel = 1'b1;
    logic       loss_in  = 1'b0;
    logic       fault_in = 1'b0;
    logic       rx_pos   = 1'b0;
    logic       rx_neg   = 1'b0;
    logic       sclk, cs_n, serial_data_in, serial_data_out, serial_data_out_oe;
    logic       int_n_out, int_n_oe, rst_pulse, rx_pos_out, rx_neg_out;
    logic [7:0] rdata;
    ctrl_s      line_ctrl;
    int         num_errors  = 0;
    int         check_count = 0;
    int         pulse_count = 0;
    logic [7:0] modes [6] = '{8'h84, 8'h48, 8'hcc, 8'h30, 8'hb4, 8'h1c};
    // The interrupt pin is open drain with a pull-up.
    wire        int_line = int_n_oe ? int_n_out : 1'b1;
    always #5 ref_clk = ~ref_clk;
    always #7.3 rclk = ~rclk;
    // Counted on the falling edge, away from the edge that launches the pulse.
    always @(negedge ref_clk) if (rst_pulse === 1'b1) pulse_count++;
    line_serial_port line_serial_port_inst
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in),
        .clock_edge_select(edge_sel), .signal_loss_in(loss_in), .driver_fault_in(fault_in),
        .rclk(rclk), .rx_pos_in(rx_pos), .rx_neg_in(rx_neg), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .line_ctrl(line_ctrl),
        .device_reset_pulse(rst_pulse), .receive_positive_data(rx_pos_out), .receive_negative_data(rx_neg_out)
    );
    host_serial_model host_serial_model_inst
    (
        .sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .edge_sel(edge_sel)
    );
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] st(input logic sl, input logic df, input logic [2:0] len, input logic [2:0] c);
        return {c[0], c[1], c[2], len, df, sl};
    endfunction : st
    function automatic logic [2:0] mode_code(input logic [7:0] m);
        if (m[5]) return CODE_REMOTE_LOOPBACK;
        return m[6] ? (m[7] ? CODE_ONES_LL : CODE_LOCAL_LOOPBACK) : (m[7] ? CODE_ONES : CODE_IDLE);
    endfunction : mode_code
    task automatic end_sim;
        if (num_errors == 0 && check_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        logic [7:0] r;
        host_serial_model_inst.xfer(cmd, d, 16, r);
        repeat (8) @(negedge ref_clk);
        `CHK(host_serial_model_inst.oe_seen, 1'b0)
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] r;
        host_serial_model_inst.xfer(cmd, 8'h00, 16, r);
        `CHK(r, exp)
        `CHK(serial_data_out_oe, 1'b0)
    endtask : rd
    task automatic wait_int(input logic lvl);
        int i;
        for (i = 0; i < 40 && int_line !== lvl; i++) @(negedge ref_clk);
        if (i == 40)
        begin
            num_errors++;
            end_sim();
        end
        `CHK(int_line, lvl)
    endtask : wait_int
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(negedge ref_clk);
        `CHK(line_ctrl, 8'h00)
        rd(8'h21, 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            @(posedge ref_clk);
            edge_sel <= e[0];
            rx_pos   <= e[0];
            rx_neg   <= ~e[0];
            repeat (8) @(negedge ref_clk);
            `CHK({rx_pos_out, rx_neg_out}, {e[0], ~e[0]})
            foreach (modes[i])
            begin
                wr(8'h20, modes[i]);
                `CHK(line_ctrl, modes[i])
                rd(e[0] ? 8'ha1 : 8'h21, st(1'b0, 1'b0, modes[i][4:2], mode_code(modes[i])));
            end
        end
        wr(8'h22, 8'h84);
        `CHK(line_ctrl, 8'h1c)
        host_serial_model_inst.xfer(8'h23, 8'h00, 16, rdata);
        `CHK(host_serial_model_inst.oe_seen, 1'b0)
        host_serial_model_inst.xfer(8'h21, 8'h00, 12, rdata);
        `CHK(serial_data_out_oe, 1'b0)
        `CHK(rdata[3:0], 4'hc)
        @(posedge ref_clk);
        loss_in <= 1'b1;
        wait_int(1'b0);
        rd(8'h21, st(1'b1, 1'b0, 3'h7, CODE_SLOSS));
        `CHK(int_line, 1'b0)
        @(posedge ref_clk);
        fault_in <= 1'b1;
        repeat (8) @(negedge ref_clk);
        rd(8'h21, st(1'b1, 1'b1, 3'h7, CODE_BOTH));
        wr(8'h20, 8'h1d);
        `CHK(int_line, 1'b0)
        rd(8'h21, st(1'b1, 1'b1, 3'h7, CODE_DFAULT));
        wr(8'h20, 8'h1f);
        `CHK(int_line, 1'b1)
        rd(8'h21, st(1'b1, 1'b1, 3'h7, CODE_IDLE));
        @(posedge ref_clk);
        loss_in  <= 1'b0;
        fault_in <= 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK(int_line, 1'b1)
        rd(8'h21, st(1'b0, 1'b0, 3'h7, CODE_IDLE));
        wr(8'h20, 8'h1c);
        @(posedge ref_clk);
        fault_in <= 1'b1;
        wait_int(1'b0);
        rd(8'h21, st(1'b0, 1'b1, 3'h7, CODE_DFAULT));
        `CHK(pulse_count, 0)
        wr(8'h20, 8'h60);
        `CHK(line_ctrl, 8'h00)
        `CHK(int_line, 1'b1)
        `CHK(pulse_count, 1)
        rd(8'h21, st(1'b1, 1'b1, 3'h0, CODE_IDLE));
        end_sim();
    end
endmodule : line_serial_port_test
